// *** sbsf_pkg.sv ***
`default_nettype none
package sbsf_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] SBSF_IDX_CONTROL = 8'ha0;
	localparam logic [7:0] SBSF_IDX_TX_HOLD = 8'ha1;
	localparam logic [7:0] SBSF_IDX_STATUS = 8'ha2;
	localparam logic [7:0] SBSF_IDX_IRQ_STAT = 8'ha3;
	localparam logic [7:0] SBSF_IDX_IRQ_MASK = 8'ha4;
	localparam logic [7:0] SBSF_IDX_RX_BUF = 8'had;
	localparam int SBSF_ADDR_W = 12;
	// Field positions
	localparam int SBSF_CTRL_TX_EN = 5;
	localparam int SBSF_ST_TX_EMPTY = 7;
	localparam int SBSF_ST_RX_FULL = 6;
	localparam int SBSF_IRQ_TX = 0;
	localparam int SBSF_IRQ_RX = 1;
	// Values after reset
	localparam logic [7:0] SBSF_RST_CONTROL = 8'h00;
	localparam logic [7:0] SBSF_RST_TX_HOLD = 8'h00;
	localparam logic [7:0] SBSF_RST_RX_BUF = 8'h00;
	localparam logic [1:0] SBSF_RST_IRQ = 2'h0;
	localparam logic SBSF_RST_TX_EMPTY = 1'b1;
	localparam logic SBSF_RST_RX_FULL = 1'b0;
	// AXI responses
	localparam logic [1:0] SBSF_RESP_OKAY = 2'h0;
	localparam logic [1:0] SBSF_RESP_SLVERR = 2'h2;
	// Status flags carried together
	typedef struct packed {
		logic tx_empty;
		logic rx_full;
	} sbsf_flags_t;
	// Byte address of a register index
	function automatic logic [SBSF_ADDR_W-1:0] sbsf_byte_addr(input logic [7:0] idx);
		sbsf_byte_addr = {2'h0, idx, 2'h0};
	endfunction
endpackage
`default_nettype wire

// *** sbsf_top.sv ***
// Overview of operation
// - Transmit empty flag reads 0 while a written byte awaits the shift register.
// - Through the status register, software clears transmit empty only by reading it as 1, then writing 0.
// - Writing a byte to the holding register clears transmit empty while transmit enable is 1 and no transfer happens in the same cycle.
// - Transmit empty is forced to 1 while transmit enable is 0.
// - Transfer from holding to shift register sets transmit empty to 1.
// - Status flags accept only a written 0 as clear; a written 1 is ignored.
`timescale 1ns/1ps
`default_nettype none
module sbsf_top
	import sbsf_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [SBSF_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [SBSF_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [7:0] TX_DATA,
	output logic TX_DATA_VALID,
	input wire logic TX_SHIFT_LOAD,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_LOAD,
	output logic IRQ
);
	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] control;
	logic [7:0] tx_holding_reg;
	logic [7:0] rx_data_buffer;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	sbsf_flags_t flags;
	sbsf_flags_t armed;
	sbsf_flags_t next_flags;
	sbsf_flags_t next_armed;
	logic [1:0] next_irq_status;
	// Write channel holding
	logic aw_held;
	logic w_held;
	logic [SBSF_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire do_write = aw_held && w_held && !S_AXI_BVALID;
	wire do_read = S_AXI_ARVALID && S_AXI_ARREADY;
	wire lane0 = w_strb[0];
	wire wr_ctrl = do_write && lane0 && aw_addr == sbsf_byte_addr(SBSF_IDX_CONTROL);
	wire wr_hold = do_write && lane0 && aw_addr == sbsf_byte_addr(SBSF_IDX_TX_HOLD);
	wire wr_stat = do_write && lane0 && aw_addr == sbsf_byte_addr(SBSF_IDX_STATUS);
	wire wr_istat = do_write && lane0 && aw_addr == sbsf_byte_addr(SBSF_IDX_IRQ_STAT);
	wire wr_imask = do_write && lane0 && aw_addr == sbsf_byte_addr(SBSF_IDX_IRQ_MASK);
	wire wr_known = aw_addr == sbsf_byte_addr(SBSF_IDX_CONTROL) ||
		aw_addr == sbsf_byte_addr(SBSF_IDX_TX_HOLD) ||
		aw_addr == sbsf_byte_addr(SBSF_IDX_STATUS) ||
		aw_addr == sbsf_byte_addr(SBSF_IDX_IRQ_STAT) ||
		aw_addr == sbsf_byte_addr(SBSF_IDX_IRQ_MASK);
	wire rd_ctrl = S_AXI_ARADDR == sbsf_byte_addr(SBSF_IDX_CONTROL);
	wire rd_hold = S_AXI_ARADDR == sbsf_byte_addr(SBSF_IDX_TX_HOLD);
	wire rd_stat_hit = S_AXI_ARADDR == sbsf_byte_addr(SBSF_IDX_STATUS);
	wire rd_istat = S_AXI_ARADDR == sbsf_byte_addr(SBSF_IDX_IRQ_STAT);
	wire rd_imask = S_AXI_ARADDR == sbsf_byte_addr(SBSF_IDX_IRQ_MASK);
	wire rd_rx_hit = S_AXI_ARADDR == sbsf_byte_addr(SBSF_IDX_RX_BUF);
	wire rd_stat = do_read && rd_stat_hit;
	wire rd_rx = do_read && rd_rx_hit;
	wire tx_en = control[SBSF_CTRL_TX_EN];
	wire [7:0] status_byte = {flags.tx_empty, flags.rx_full, 6'h00};

	// Handshake outputs
	assign S_AXI_AWREADY = !aw_held;
	assign S_AXI_WREADY = !w_held;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	////////////////////////////////////////////////////////////////////////////////
	// Flag next values; hardware set wins over software clear
	always_comb begin
		next_flags = flags;
		next_armed = armed;
		// Reading a flag as 1 arms its clear
		if (rd_stat && flags.tx_empty) begin
			next_armed.tx_empty = 1'b1;
		end
		if (rd_stat && flags.rx_full) begin
			next_armed.rx_full = 1'b1;
		end
		if (wr_stat) begin
			next_armed = '0;
		end
		// Only a written 0 on an armed flag clears it
		if (wr_stat && armed.tx_empty && !w_data[SBSF_ST_TX_EMPTY]) begin
			next_flags.tx_empty = 1'b0;
		end
		if (wr_stat && armed.rx_full && !w_data[SBSF_ST_RX_FULL]) begin
			next_flags.rx_full = 1'b0;
		end
		if (wr_hold) begin
			next_flags.tx_empty = 1'b0;
		end
		if (!tx_en || TX_SHIFT_LOAD) begin
			next_flags.tx_empty = 1'b1;
		end
		if (rd_rx) begin
			next_flags.rx_full = 1'b0;
		end
		if (RX_LOAD) begin
			next_flags.rx_full = 1'b1;
		end
	end

	// Interrupt status: events set, written ones clear, set wins
	always_comb begin
		next_irq_status = irq_status;
		if (wr_istat) begin
			next_irq_status = irq_status & ~w_data[1:0];
		end
		if (TX_SHIFT_LOAD) begin
			next_irq_status[SBSF_IRQ_TX] = 1'b1;
		end
		if (RX_LOAD) begin
			next_irq_status[SBSF_IRQ_RX] = 1'b1;
		end
	end

	// Read data selection
	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp = SBSF_RESP_OKAY;
		if (rd_ctrl) begin
			next_rdata = {24'h000000, control};
		end else if (rd_hold) begin
			next_rdata = {24'h000000, tx_holding_reg};
		end else if (rd_stat_hit) begin
			next_rdata = {24'h000000, status_byte};
		end else if (rd_istat) begin
			next_rdata = {30'h0, irq_status};
		end else if (rd_imask) begin
			next_rdata = {30'h0, irq_mask};
		end else if (rd_rx_hit) begin
			next_rdata = {24'h000000, rx_data_buffer};
		end else begin
			next_rresp = SBSF_RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write channels
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= SBSF_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_held) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_known ? SBSF_RESP_OKAY : SBSF_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= SBSF_RESP_OKAY;
		end else if (do_read) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Software registers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			control <= SBSF_RST_CONTROL;
			tx_holding_reg <= SBSF_RST_TX_HOLD;
			irq_mask <= SBSF_RST_IRQ;
		end else begin
			if (wr_ctrl) control <= w_data[7:0];
			if (wr_hold) tx_holding_reg <= w_data[7:0];
			if (wr_imask) irq_mask <= w_data[1:0];
		end
	end

	// Flags, receive buffer and interrupt status
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			flags <= '{tx_empty: SBSF_RST_TX_EMPTY, rx_full: SBSF_RST_RX_FULL};
			armed <= '0;
			rx_data_buffer <= SBSF_RST_RX_BUF;
			irq_status <= SBSF_RST_IRQ;
		end else begin
			flags <= next_flags;
			armed <= next_armed;
			irq_status <= next_irq_status;
			if (RX_LOAD) rx_data_buffer <= RX_DATA;
		end
	end

	// Shift register side and interrupt
	assign TX_DATA = tx_holding_reg;
	assign TX_DATA_VALID = !flags.tx_empty && tx_en;
	assign IRQ = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_quiet_tx;
		tx_en && !TX_SHIFT_LOAD && !wr_hold;
	endsequence
	sequence s_armed_zero;
		wr_stat && armed.tx_empty && !w_data[SBSF_ST_TX_EMPTY];
	endsequence

	pending_byte_a: assert property (!flags.tx_empty ##0 s_quiet_tx |=> !flags.tx_empty)
		else $error("Pending byte not offered");
	hold_write_a: assert property (wr_hold && tx_en && !TX_SHIFT_LOAD |=> !flags.tx_empty)
		else $error("Holding write left flag set");
	tx_disable_a: assert property (!tx_en |=> flags.tx_empty)
		else $error("Flag not set while disabled");
	shift_load_a: assert property (TX_SHIFT_LOAD |=> flags.tx_empty && irq_status[SBSF_IRQ_TX])
		else $error("Transfer did not set flag");
	armed_clear_a: assert property (s_armed_zero and s_quiet_tx |=> !flags.tx_empty)
		else $error("Armed clear not honoured");
	unarmed_keep_a: assert property (wr_stat && !armed.tx_empty ##0 s_quiet_tx |=>
		$stable(flags.tx_empty))
		else $error("Clear without prior read");
	one_ignored_a: assert property (wr_stat && w_data[SBSF_ST_TX_EMPTY] ##0 s_quiet_tx |=>
		$stable(flags.tx_empty))
		else $error("Written one changed flag");
	rx_load_a: assert property (RX_LOAD |=> flags.rx_full && rx_data_buffer == $past(RX_DATA))
		else $error("Receive load not flagged");
	rx_read_a: assert property (rd_rx && !RX_LOAD |=> !flags.rx_full && S_AXI_RVALID &&
		S_AXI_RDATA[7:0] == $past(rx_data_buffer))
		else $error("Buffer read kept full flag");
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import sbsf_pkg::*;
;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [SBSF_ADDR_W-1:0] awa = 12'h000;
	logic [SBSF_ADDR_W-1:0] ara = 12'h000;
	logic [31:0] wd = 32'h0;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, tsl = 1'h0, rxl = 1'h0;
	logic [7:0] rxd = 8'h00;
	logic [7:0] txd, hb, xb;
	logic awr, wr, bv, arr, rv, txv, irq;
	logic [1:0] bresp, rresp, rs, wresp;
	logic [3:0] ws = 4'hf;
	logic [31:0] rd, v;
	logic e_empty, e_full;
	logic [1:0] e_irq;
	int failures = 0, checked = 0, cyc = 0, seed = 64;

	sbsf_top i_sbsf_top (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .TX_DATA(txd),
		.TX_DATA_VALID(txv), .TX_SHIFT_LOAD(tsl), .RX_DATA(rxd), .RX_LOAD(rxl), .IRQ(irq));

	////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	// Compare, report and close
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Bus master: hold each channel until its ready, wait for the answer
	task automatic wreg(input logic [7:0] i, input logic [31:0] d);
		@(posedge clk);
		awa <= {2'h0, i, 2'h0};
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wr) wv <= 1'h0;
		end while (!bv);
		wresp = bresp;
		br <= 1'h0;
	endtask
	task automatic rreg(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		ara <= {2'h0, i, 2'h0};
		arv <= 1'h1;
		rr <= 1'h1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'h0;
		end while (!rv);
		d = rd;
		r = rresp;
		rr <= 1'h0;
	endtask
	// Status read against the model flags
	task automatic sts;
		rreg(SBSF_IDX_STATUS, v, rs);
		chk(v, {24'h000000, e_empty, e_full, 6'h00});
		chk(32'(rs), 32'(SBSF_RESP_OKAY));
	endtask
	// One-cycle pulse from the shift side
	task automatic pulse(input logic tx, input logic [7:0] d);
		@(posedge clk);
		rxd <= d;
		tsl <= tx;
		rxl <= !tx;
		@(posedge clk);
		tsl <= 1'h0;
		rxl <= 1'h0;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		e_empty = 1'h1;
		e_full = 1'h0;
		e_irq = 2'h0;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		rreg(SBSF_IDX_RX_BUF, v, rs);
		chk(v, 32'h0);
		sts();
		hb = 8'($random(seed));
		wreg(SBSF_IDX_TX_HOLD, {24'h0, hb});
		chk(32'(wresp), 32'(SBSF_RESP_OKAY));
		sts();
		chk(32'(txv), 32'h0);
		wreg(SBSF_IDX_CONTROL, 32'h20);
		wreg(SBSF_IDX_TX_HOLD, {24'h0, hb});
		e_empty = 1'h0;
		sts();
		chk(32'({txv, txd}), 32'({1'h1, hb}));
		pulse(1'h1, 8'h00);
		e_empty = 1'h1;
		e_irq = 2'h1;
		sts();
		chk(32'(txv), 32'h0);
		wreg(SBSF_IDX_STATUS, 32'hff);
		sts();
		// The read above armed the clear, so this write of 0 takes effect
		wreg(SBSF_IDX_STATUS, 32'h00);
		e_empty = 1'h0;
		sts();
		// Flag set again, then a write of 0 with no read first is ignored
		pulse(1'h1, 8'h00);
		e_empty = 1'h1;
		wreg(SBSF_IDX_STATUS, 32'h00);
		sts();
		wreg(SBSF_IDX_STATUS, 32'h00);
		e_empty = 1'h0;
		sts();
		wreg(SBSF_IDX_CONTROL, 32'h00);
		e_empty = 1'h1;
		sts();
		xb = 8'($random(seed));
		pulse(1'h0, xb);
		e_full = 1'h1;
		e_irq = 2'h3;
		sts();
		rreg(SBSF_IDX_RX_BUF, v, rs);
		chk(v, {24'h0, xb});
		e_full = 1'h0;
		sts();
		rreg(SBSF_IDX_IRQ_STAT, v, rs);
		chk(v, {30'h0, e_irq});
		chk(32'(irq), 32'h0);
		wreg(SBSF_IDX_IRQ_MASK, 32'h3);
		chk(32'(irq), 32'h1);
		wreg(SBSF_IDX_IRQ_STAT, 32'h1);
		e_irq = 2'h2;
		rreg(SBSF_IDX_IRQ_STAT, v, rs);
		chk(v, {30'h0, e_irq});
		chk(32'(irq), 32'h1);
		wreg(SBSF_IDX_IRQ_STAT, 32'h2);
		chk(32'(irq), 32'h0);
		// A write with lane 0 disabled is answered but changes nothing
		ws <= 4'h0;
		wreg(SBSF_IDX_IRQ_MASK, 32'h0);
		ws <= 4'hf;
		rreg(SBSF_IDX_IRQ_MASK, v, rs);
		chk(v, 32'h3);
		rreg(8'h00, v, rs);
		chk(32'(rs), 32'(SBSF_RESP_SLVERR));
		chk(v, 32'h0);
		wreg(8'h00, 32'h0);
		chk(32'(wresp), 32'(SBSF_RESP_SLVERR));
		wrap_up();
	end
endmodule
`default_nettype wire
